// ===== src/sgc_regs.sv
// Summary of operation
// RULE1 - null VID replaced by port VID when set
// RULE2 - threshold bits 10:8 and 7:0 from two registers
// RULE3 - period 50ms at 100M, 500ms at 10M
// RULE4 - threshold resets to 0x4a, high bits zero
// RULE5 - three test registers read 00, 4c, 00
// RULE6 - per-port rmii edge select, 1 negative
// RULE7 - led mode defaults from strap at reset; here reset loads 0 and the strap is taken on the first clock after release
// RULE8 - read data edge select, 1 rising
// RULE9 - drop broadcast blocks past threshold per period
// RULE10 - phy power save bit enables power saving
`timescale 1ns/1ns
`default_nettype none
module sgc_regs
  import sgc_pkg::*;
#(
  parameter int CYC_100M = sgc_pkg::SGC_CYC_100M,  // shorten for simulation
  parameter int CYC_10M  = sgc_pkg::SGC_CYC_10M
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // register access from the management interface
  input  wire logic [7:0]            reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [7:0]            reg_wdata,
  output logic      [7:0]            reg_rdata,
  // strap
  input  wire logic                  led_mode_strap_pin,
  // vid path
  input  wire logic                  vid_valid,
  input  wire logic [11:0]           vid_in,
  input  wire logic [11:0]           port_vid,
  output logic      [11:0]           vid_out,
  output logic                       vid_out_valid,
  // storm path, one lane per input port
  input  wire logic [sgc_pkg::SGC_PORTS-1:0] bc_block,
  input  wire logic [sgc_pkg::SGC_PORTS-1:0] port_is_10m,
  output logic      [sgc_pkg::SGC_PORTS-1:0] bc_drop,
  // steering outputs
  output logic                       third_port_reduced_mii_neg_edge,
  output logic                       fourth_port_reduced_mii_neg_edge,
  output logic                       phy_power_save,
  output logic                       led_mode,
  output logic                       rd_launch_rising
);
  import sgc_pkg::*;

  logic       null_vid_q;      // null vid replacement enable
  logic [2:0] storm_hi_q;      // threshold bits 10:8
  logic [7:0] storm_lo_q;      // threshold bits 7:0
  logic       p3_edge_q;       // port 3 refclk edge
  logic       p4_edge_q;       // port 4 refclk edge
  logic       phy_pwr_q;       // phy power save
  logic       led_mode_q;      // led mapping mode
  logic       rd_edge_q;       // read data launch edge
  logic       strap_done_q;    // strap captured once after release
  logic [10:0] threshold;      // assembled storm threshold
  logic        tick_100m;      // period restart for fast ports
  logic        tick_10m;       // period restart for slow ports
  logic [SGC_PORTS-1:0] drop_d;

  // builds the full register image for a read
  function automatic logic [7:0] sgc_read(input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      SGC_ADDR_VID_STORM_HI: r = {4'h0, null_vid_q, storm_hi_q};
      SGC_ADDR_STORM_LO:     r = storm_lo_q;
      SGC_ADDR_TEST_A:       r = SGC_VAL_TEST_A;  // RULE5
      SGC_ADDR_TEST_B:       r = SGC_VAL_TEST_B;  // RULE5
      SGC_ADDR_TEST_C:       r = SGC_VAL_TEST_C;  // RULE5
      SGC_ADDR_EDGE_LED_PWR: r = {p3_edge_q, p4_edge_q, 2'b00, phy_pwr_q,
                                  1'b0, led_mode_q, rd_edge_q};
      default:               r = 8'h00;  // unmapped reads as zero
    endcase
    return r;
  endfunction : sgc_read

  // writable fields; test registers and reserved bits ignore writes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      null_vid_q <= 1'b0;              // RULE1
      storm_hi_q <= SGC_RST_STORM_HI;  // RULE4
      storm_lo_q <= SGC_RST_STORM_LO;  // RULE4
      p3_edge_q  <= 1'b0;              // RULE6
      p4_edge_q  <= 1'b0;              // RULE6
      phy_pwr_q  <= 1'b0;              // RULE10
      rd_edge_q  <= 1'b0;              // RULE8
    end
    else if (reg_wr)
    begin
      if (reg_addr == SGC_ADDR_VID_STORM_HI)
      begin
        null_vid_q <= reg_wdata[SGC_BIT_NULL_VID];
        storm_hi_q <= reg_wdata[2:0];  // RULE2
      end
      if (reg_addr == SGC_ADDR_STORM_LO)
        storm_lo_q <= reg_wdata;  // RULE2
      if (reg_addr == SGC_ADDR_EDGE_LED_PWR)
      begin
        p3_edge_q <= reg_wdata[SGC_BIT_P3_EDGE];  // RULE6
        p4_edge_q <= reg_wdata[SGC_BIT_P4_EDGE];  // RULE6
        phy_pwr_q <= reg_wdata[SGC_BIT_PHY_PWR];  // RULE10
        rd_edge_q <= reg_wdata[SGC_BIT_RD_EDGE];  // RULE8
      end
    end
  end

  // led mode: strap caught on the first clock after reset release,
  // since an async reset may only load a constant
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      led_mode_q   <= 1'b0;
      strap_done_q <= 1'b0;
    end
    else if (!strap_done_q)
    begin
      led_mode_q   <= led_mode_strap_pin;  // RULE7
      strap_done_q <= 1'b1;
    end
    else if (reg_wr && reg_addr == SGC_ADDR_EDGE_LED_PWR)
      led_mode_q <= reg_wdata[SGC_BIT_LED_MODE];
  end

  // registered read data, valid the cycle after reg_rd
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= sgc_read(reg_addr);
  end

  // null vid substitution, one cycle of latency
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vid_out       <= 12'h000;
      vid_out_valid <= 1'b0;
    end
    else
    begin
      vid_out_valid <= vid_valid;
      if (null_vid_q && vid_in == 12'h000)
        vid_out <= port_vid;  // RULE1
      else
        vid_out <= vid_in;    // RULE1
    end
  end

  assign threshold = {storm_hi_q, storm_lo_q};  // RULE2

  // two period timers, one per line rate
  sgc_period_timer #(.PERIOD_CYC(CYC_100M)) u_tmr_100m (  // RULE3
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (tick_100m)
  );
  sgc_period_timer #(.PERIOD_CYC(CYC_10M)) u_tmr_10m (  // RULE3
    .clk   (clk),
    .rst_n (rst_n),
    .tick  (tick_10m)
  );

  // per-port counters pick the period matching their speed
  for (genvar p = 0; p < SGC_PORTS; p++)
  begin : g_port
    sgc_storm_port u_port (
      .clk       (clk),
      .rst_n     (rst_n),
      .restart   (port_is_10m[p] ? tick_10m : tick_100m),  // RULE3
      .bc_block  (bc_block[p]),
      .threshold (threshold),
      .drop      (drop_d[p])
    );
  end

  // registered outputs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bc_drop                          <= '0;
      third_port_reduced_mii_neg_edge  <= 1'b0;
      fourth_port_reduced_mii_neg_edge <= 1'b0;
      phy_power_save                   <= 1'b0;
      led_mode                         <= 1'b0;
      rd_launch_rising                 <= 1'b0;
    end
    else
    begin
      bc_drop                          <= drop_d;     // RULE9
      third_port_reduced_mii_neg_edge  <= p3_edge_q;  // RULE6
      fourth_port_reduced_mii_neg_edge <= p4_edge_q;  // RULE6
      phy_power_save                   <= phy_pwr_q;  // RULE10
      led_mode                         <= led_mode_q; // RULE7
      rd_launch_rising                 <= rd_edge_q;  // RULE8
    end
  end
endmodule : sgc_regs
`default_nettype wire

// ===== src/sgc_pkg.sv
package sgc_pkg;
  // register indices on the management bus
  localparam logic [7:0] SGC_ADDR_VID_STORM_HI = 8'h06;
  localparam logic [7:0] SGC_ADDR_STORM_LO     = 8'h07;
  localparam logic [7:0] SGC_ADDR_TEST_A       = 8'h08;
  localparam logic [7:0] SGC_ADDR_TEST_B       = 8'h09;
  localparam logic [7:0] SGC_ADDR_TEST_C       = 8'h0a;
  localparam logic [7:0] SGC_ADDR_EDGE_LED_PWR = 8'h0b;

  // reset values
  localparam logic [7:0] SGC_RST_STORM_LO = 8'h4a;
  localparam logic [2:0] SGC_RST_STORM_HI = 3'h0;
  localparam logic [7:0] SGC_VAL_TEST_A   = 8'h00;
  localparam logic [7:0] SGC_VAL_TEST_B   = 8'h4c;
  localparam logic [7:0] SGC_VAL_TEST_C   = 8'h00;

  // field positions in the vid/storm-high register
  localparam int SGC_BIT_NULL_VID = 3;
  // field positions in the edge/led/power register
  localparam int SGC_BIT_P3_EDGE  = 7;
  localparam int SGC_BIT_P4_EDGE  = 6;
  localparam int SGC_BIT_PHY_PWR  = 3;
  localparam int SGC_BIT_LED_MODE = 1;
  localparam int SGC_BIT_RD_EDGE  = 0;

  // storm measuring periods
  localparam int SGC_CLK_MHZ        = 125;
  localparam int SGC_PERIOD_100M_MS = 50;
  localparam int SGC_PERIOD_10M_MS  = 500;
  localparam int SGC_CYC_100M       = SGC_PERIOD_100M_MS * 1000 * SGC_CLK_MHZ;
  localparam int SGC_CYC_10M        = SGC_PERIOD_10M_MS * 1000 * SGC_CLK_MHZ;
  localparam int SGC_PORTS          = 4;
endpackage : sgc_pkg

// ===== src/sgc_period_timer.sv
`timescale 1ns/1ns
`default_nettype none
// free-running period counter; emits a one-cycle restart pulse
module sgc_period_timer #(
  parameter int PERIOD_CYC = 6250000
) (
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      tick
);
  logic [31:0] cnt_q;  // cycles elapsed in current period

  // count up to the period, then pulse and wrap
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 32'h0;
      tick  <= 1'b0;
    end
    else if (cnt_q == 32'(PERIOD_CYC - 1))
    begin
      cnt_q <= 32'h0;
      tick  <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 32'h1;
      tick  <= 1'b0;
    end
  end
endmodule : sgc_period_timer
`default_nettype wire

// ===== src/sgc_storm_port.sv
`timescale 1ns/1ns
`default_nettype none
// per-port broadcast block counter against the storm threshold
module sgc_storm_port (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        restart,    // period restart pulse
  input  wire logic        bc_block,   // one broadcast 64-byte block seen
  input  wire logic [10:0] threshold,
  output logic             drop        // block must be dropped
);
  logic [10:0] cnt_q;  // blocks admitted this period

  // drop once threshold reached; saturates so it never wraps
  always_comb
  begin
    drop = bc_block && (cnt_q >= threshold);  // RULE9
  end

  // count admitted blocks, cleared at each period restart
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= 11'h0;
    else if (restart)
      cnt_q <= 11'h0;  // RULE9
    else if (bc_block && !drop)
      cnt_q <= cnt_q + 11'h1;
  end
endmodule : sgc_storm_port
`default_nettype wire

// ===== test/sgc_regs_props.sv
`timescale 1ns/1ns
`default_nettype none
// watches register side effects at the block ports
module sgc_regs_props
  import sgc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic        vid_valid,
  input wire logic [11:0] vid_in,
  input wire logic [11:0] vid_out,
  input wire logic        vid_out_valid,
  input wire logic        third_port_reduced_mii_neg_edge,
  input wire logic        fourth_port_reduced_mii_neg_edge,
  input wire logic        phy_power_save,
  input wire logic        led_mode,
  input wire logic        rd_launch_rising
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // control write: register on the next edge, output one edge later
  sequence ctl_wr;
    reg_wr && reg_addr == SGC_ADDR_EDGE_LED_PWR;
  endsequence
  sequence ro_zero_rd;
    reg_rd && (reg_addr == SGC_ADDR_TEST_A || reg_addr == SGC_ADDR_TEST_C);
  endsequence
  chk_p3_edge: assert property (
    ctl_wr |-> ##2 third_port_reduced_mii_neg_edge == $past(reg_wdata[7], 2))
    else $error("port three edge bit wrong");
  chk_p4_edge: assert property (
    ctl_wr |-> ##2 fourth_port_reduced_mii_neg_edge == $past(reg_wdata[6], 2))
    else $error("port four edge bit wrong");
  chk_power_save: assert property (
    ctl_wr |-> ##2 phy_power_save == $past(reg_wdata[3], 2))
    else $error("power save bit wrong");
  chk_led_mode: assert property (
    ctl_wr |-> ##2 led_mode == $past(reg_wdata[1], 2))
    else $error("led mode bit wrong");
  chk_read_edge: assert property (
    ctl_wr |-> ##2 rd_launch_rising == $past(reg_wdata[0], 2))
    else $error("read edge bit wrong");
  chk_test_b: assert property (
    reg_rd && reg_addr == SGC_ADDR_TEST_B |=> reg_rdata == SGC_VAL_TEST_B)
    else $error("test register b read wrong");
  chk_test_ac: assert property (
    ro_zero_rd |=> reg_rdata == 8'h00)
    else $error("test register a or c read wrong");
  chk_vid_pass: assert property (
    vid_valid && vid_in != 12'h000 |=> vid_out_valid && vid_out == $past(vid_in))
    else $error("non-null vid altered");
endmodule : sgc_regs_props
bind sgc_regs sgc_regs_props i_chk (.clk, .rst_n, .reg_addr, .reg_wr, .reg_rd,
  .reg_wdata, .reg_rdata, .vid_valid, .vid_in, .vid_out, .vid_out_valid,
  .third_port_reduced_mii_neg_edge, .fourth_port_reduced_mii_neg_edge,
  .phy_power_save, .led_mode, .rd_launch_rising);
`default_nettype wire

// ===== test/switch_global_control_regs_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module switch_global_control_regs_tb_top;
  import sgc_pkg::*;
  logic        clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic        vid_valid = 1'h0, strap = 1'h1;     // strap pulled up: led mode 1
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [11:0] vid_in = 12'h000, port_vid = 12'h5a3, vid_out;
  logic        vid_out_valid, p3, p4, pwr, led, rde;
  logic [3:0]  bc = 4'h0, slow = 4'h0, drop;
  int          fails = 0, compares = 0, cyc = 0, n0, n1, n2, n3;
  int          ctl_b [5] = '{7, 6, 3, 1, 0};       // control bits, output order
  logic [7:0]  ro_v [3] = '{8'h00, 8'h4c, 8'h00};
  always #4 clk = ~clk;
  sgc_regs #(.CYC_100M(100), .CYC_10M(1000)) i_dut (
    .clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .led_mode_strap_pin(strap), .vid_valid, .vid_in, .port_vid, .vid_out,
    .vid_out_valid, .bc_block(bc), .port_is_10m(slow), .bc_drop(drop),
    .third_port_reduced_mii_neg_edge(p3), .fourth_port_reduced_mii_neg_edge(p4),
    .phy_power_save(pwr), .led_mode(led), .rd_launch_rising(rde));
  task automatic check(input logic [12:0] seen, input logic [12:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask : wr
  // read data is registered, so it is looked at just after the taking edge
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 check(reg_rdata, e);
  endtask : rdc
  task automatic vchk(input logic [11:0] v, input logic [11:0] e);
    @(posedge clk);
    vid_in    <= v;
    vid_valid <= 1'h1;
    @(posedge clk);
    vid_valid <= 1'h0;
    #1 check({vid_out_valid, vid_out}, {1'h1, e});
  endtask : vchk
  // tick phase is hidden, so drop totals are judged against a window
  task automatic storm(input logic [3:0] b, input logic [3:0] s, input int len);
    @(posedge clk);
    bc   <= b;
    slow <= s;
    n0 = 0;
    n1 = 0;
    n2 = 0;
    n3 = 0;
    repeat (len)
    begin
      @(posedge clk);
      #1 n0 += int'(drop[0] === 1'h1);
      n1 += int'(drop[1] === 1'h1);
      n2 += int'(drop[2] === 1'h1);
      n3 += int'(drop[3] === 1'h1);
    end
    bc <= 4'h0;
  endtask : storm
  // guard against a hang
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      test_done;
    end
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    rdc(SGC_ADDR_STORM_LO, 8'h4a);
    rdc(SGC_ADDR_VID_STORM_HI, 8'h00);
    rdc(SGC_ADDR_EDGE_LED_PWR, 8'h02);
    check(led, 1'h1);
    foreach (ro_v[i])
    begin
      wr(8'h08 + 8'(i), 8'hff);
      rdc(8'h08 + 8'(i), ro_v[i]);
    end
    rdc(8'h3f, 8'h00);
    $display("test reset_ro done");
    foreach (ctl_b[k])
    begin
      wr(SGC_ADDR_EDGE_LED_PWR, 8'h01 << ctl_b[k]);
      @(posedge clk);
      #1 check({p3, p4, pwr, led, rde}, 13'h10 >> k);
    end
    wr(SGC_ADDR_EDGE_LED_PWR, 8'hff);
    rdc(SGC_ADDR_EDGE_LED_PWR, 8'hcb);
    $display("test control done");
    vchk(12'h000, 12'h000);
    wr(SGC_ADDR_VID_STORM_HI, 8'h08);
    vchk(12'h000, port_vid);
    vchk(12'h7c1, 12'h7c1);
    $display("test vid done");
    wr(SGC_ADDR_VID_STORM_HI, 8'h00);
    wr(SGC_ADDR_STORM_LO, 8'h03);
    storm(4'hf, 4'ha, 800);
    check(n0 >= 764 && n0 <= 779, 1'h1);
    check(n1 >= 792 && n1 <= 797, 1'h1);
    check(n2 >= 764 && n2 <= 779, 1'h1);
    check(n3 >= 792 && n3 <= 797, 1'h1);
    wr(SGC_ADDR_VID_STORM_HI, 8'h01);
    wr(SGC_ADDR_STORM_LO, 8'h00);
    storm(4'hf, 4'ha, 200);
    check(n0 + n1 + n2 + n3, 0);
    $display("test storm done");
    test_done;
  end
endmodule : switch_global_control_regs_tb_top
`default_nettype wire
